//--- dv/dcm_maint_monitor.sv
// concurrent checks on the data cache maintenance ports
`timescale 1ns/1ps
`default_nettype none
module dcm_maint_monitor (
  input wire logic                  sys_clk,
  input wire logic                  sys_rst,
  input wire dcm_pkg::dcm_req_t     req,
  input wire logic                  mem_done,
  input wire logic                  stall_q,
  input wire logic                  result_valid_q,
  input wire dcm_pkg::dcm_mem_req_t mem_req_q
);
  import dcm_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic [7:0] len_q;
  dcm_op_t    op_q;

  // length of the stall that is running and the op that started it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      len_q <= 8'h00;
      op_q  <= OP_NONE;
    end else begin
      len_q <= stall_q ? len_q + 8'h01 : 8'h00;
      if (req.valid && req.slot == SLOT_SPECIAL && !stall_q) op_q <= req.op;
    end
  end

  sequence s_take(dcm_op_t o);
    req.valid && req.slot == SLOT_SPECIAL && req.op == o && !stall_q;
  endsequence
  sequence s_two_stalls;
    stall_q ##1 stall_q ##1 !stall_q;
  endsequence

  chk_rdtag_no_stall: assert property (s_take(OP_RDTAG) |=> result_valid_q && !stall_q)
    else $error("tag read stalled or gave no result");
  chk_rdstat_one_stall: assert property (s_take(OP_RDSTAT) |=> result_valid_q && stall_q ##1 !stall_q)
    else $error("status read stall not one cycle");
  chk_inval_stall_two: assert property (s_take(OP_INVAL) |=> stall_q |-> s_two_stalls)
    else $error("invalidate stall not two cycles");
  chk_inval_no_wb: assert property (s_take(OP_INVAL) |=> (!(mem_req_q.valid && mem_req_q.write))[*3])
    else $error("invalidate wrote a block back");
  chk_stall_len_op: assert property ($fell(stall_q) |->
      (op_q == OP_COPYBACK && (len_q == CYC_CB_CLEAN || len_q >= CYC_CB_DIRTY)) ||
      (op_q == OP_INVAL && len_q == CYC_INVAL) || (op_q == OP_RDSTAT && len_q == CYC_RDSTAT) ||
      ((op_q == OP_ALLOC || op_q == OP_PREF) && (len_q == CYC_FILL_CLEAN || len_q >= CYC_FILL_DIRTY)))
    else $error("stall length wrong for the op");
  chk_wb_under_stall: assert property (mem_req_q.valid && mem_req_q.write |-> stall_q)
    else $error("writeback without core stall");
  chk_mem_req_hold: assert property (mem_req_q.valid && !mem_done |=> mem_req_q.valid && $stable(mem_req_q.addr))
    else $error("memory request dropped or changed early");
  chk_mem_req_end: assert property (mem_req_q.valid && mem_done |=> !mem_req_q.valid)
    else $error("memory request held after done");
  chk_block_align: assert property (mem_req_q.valid |-> mem_req_q.addr[5:0] == 6'h00)
    else $error("memory request not block aligned");
  chk_slot_only_five: assert property (req.valid && req.slot != SLOT_SPECIAL && !stall_q
      |=> !stall_q && !result_valid_q)
    else $error("op taken from a foreign slot");
endmodule // dcm_maint_monitor
`default_nettype wire

//--- dv/dcm_maint_tb.sv
// self-checking bench for the data cache maintenance block
`timescale 1ns/1ps
`default_nettype none
module dcm_maint_tb;
  import dcm_pkg::*;
  logic         sys_clk, sys_rst, mem_done, stall_q, result_valid_q, rv;
  dcm_req_t     req;
  dcm_store_t   store_hit;
  dcm_mem_req_t mem_req_q;
  logic [1:0]   miss_count;
  logic [2:0]   slot;
  logic [7:0]   lat;
  logic [31:0]  dram_base, dram_cacheable_limit, result_q, rq, wa;
  int           failures, samples_checked, n, wb, fl;

  dcm_maint dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .store_hit(store_hit),
    .miss_count(miss_count), .dram_base(dram_base), .dram_cacheable_limit(dram_cacheable_limit),
    .mem_done(mem_done), .stall_q(stall_q), .result_q(result_q), .result_valid_q(result_valid_q),
    .mem_req_q(mem_req_q));
  dcm_mem_model mem (.sys_clk(sys_clk), .sys_rst(sys_rst), .mem_req_q(mem_req_q), .lat(lat),
    .mem_done(mem_done));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // finished block transfers, split by direction
  always @(posedge sys_clk) begin
    if (mem_req_q.valid === 1'b1 && mem_done === 1'b1) begin
      if (mem_req_q.write) wb++;
      else fl++;
      wa = mem_req_q.addr;
    end
  end

  // wide enough for a cycle count paired with a transfer count or address
  task automatic check(logic [63:0] seen, logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  function automatic logic [31:0] ba(int t, int s);
    return {t[20:0], s[4:0], 6'h00};
  endfunction

  // one op; counts stall cycles, then waits out any background fill
  task automatic op(dcm_op_t o, dcm_amode_t am, logic [31:0] s1, logic [31:0] s2, logic [6:0] off);
    @(posedge sys_clk);
    req <= '{1'b1, slot, o, am, s1, s2, off};
    @(posedge sys_clk);
    req.valid <= 1'b0;
    wb = 0;
    fl = 0;
    #1;
    rq = result_q;
    rv = result_valid_q;
    for (n = 0; stall_q === 1'b1 && n < 300; n++) @(posedge sys_clk) #1;
    repeat (lat + 5) @(posedge sys_clk);
  endtask

  // stray upper and low bits must be ignored; offset +252
  task automatic rd(dcm_op_t o, int s, int w);
    op(o, AM_DISP, {18'h3FFFF, w[2:0], s[4:0], 6'h3C} - 32'd252, 32'h0, 7'h3F);
  endtask

  // stores never share a cycle with an op
  task automatic st(logic [31:0] a);
    @(posedge sys_clk);
    store_hit <= '{1'b1, a};
    @(posedge sys_clk);
    store_hit.valid <= 1'b0;
  endtask

  task automatic t_alloc_modes();
    logic [31:0] t;
    int d[4] = '{-4, 16, 32, 64};
    rd(OP_RDTAG, 3, 0);
    check(n, 0);
    check({rv, rq[0]}, 2'b10);
    for (int k = 0; k < 4; k++) begin
      t = ba(256 + k, 3) + 32'h24;
      op(OP_ALLOC, dcm_amode_t'(k), t - d[k], 32'h10, 7'h7F);
      check(n, CYC_FILL_CLEAN);
      check(fl, 0);
      rd(OP_RDTAG, 3, k);
      check(rq, {t[31:11], 10'h000, 1'b1});
    end
  endtask

  task automatic t_aperture();
    op(OP_ALLOC, AM_DISP, ba(16, 1), 32'h0, 7'h00);
    check(n, 0);
    op(OP_PREF, AM_INDEX, dram_cacheable_limit, 32'h40, 7'h00);
    check({n, fl}, 0);
    rd(OP_RDTAG, 1, 0);
    check(rq[0], 1'b0);
    rd(OP_RDSTAT, 1, 0);
    check(rq[9:0], LRU_RST);
  endtask

  task automatic t_copyback();
    logic [31:0] a;
    a = ba(256, 3);
    st(a + 32'h8);
    rd(OP_RDSTAT, 3, 0);
    check(n, CYC_RDSTAT);
    check(rq[17:10], 8'h01);
    op(OP_COPYBACK, AM_DISP, a + 32'd256, 32'h0, 7'h40);
    check(n, CYC_CB_DIRTY);
    check({wb, wa}, {32'd1, a});
    rd(OP_RDSTAT, 3, 0);
    check(rq[17:10], 8'h00);
    rd(OP_RDTAG, 3, 0);
    check(rq[0], 1'b1);
    op(OP_COPYBACK, AM_DISP, a, 32'h0, 7'h00);
    check({n, wb}, {CYC_CB_CLEAN, 32'd0});
    op(OP_COPYBACK, AM_DISP, ba(300, 3), 32'h0, 7'h00);
    check(n, 0);
  endtask

  task automatic t_lru();
    for (int w = 4; w < 8; w++) op(OP_ALLOC, AM_DISP, ba(256 + w, 3), 32'h0, 7'h00);
    op(OP_COPYBACK, AM_DISP, ba(258, 3), 32'h0, 7'h00);
    op(OP_ALLOC, AM_DISP, ba(900, 3), 32'h0, 7'h00);
    rd(OP_RDTAG, 3, 2);
    check(rq, {ba(900, 3) >> 11, 10'h000, 1'b1});
  endtask

  task automatic t_inval();
    st(ba(257, 3));
    op(OP_INVAL, AM_DISP, ba(257, 3) + 32'd4, 32'h0, 7'h7F);
    check({n, wb}, {CYC_INVAL, 32'd0});
    rd(OP_RDSTAT, 3, 0);
    check(rq[17:10], 8'h00);
    rd(OP_RDTAG, 3, 1);
    check(rq[0], 1'b0);
    op(OP_INVAL, AM_DISP, ba(257, 3), 32'h0, 7'h00);
    check(n, 0);
  endtask

  // slow memory, every way of the set dirty
  task automatic t_victim();
    lat <= 8'd20;
    for (int w = 0; w < 8; w++) op(OP_ALLOC, AM_DISP, ba(640 + w, 7), 32'h0, 7'h00);
    for (int w = 0; w < 8; w++) st(ba(640 + w, 7));
    op(OP_ALLOC, AM_DISP, ba(700, 7), 32'h0, 7'h00);
    check(n > 20, 1'b1);
    check(wb, 1);
    lat <= 8'd2;
  endtask

  task automatic t_prefetch();
    logic [31:0] a;
    a = ba(512, 9);
    op(OP_PREF, AM_SCALE4, a - 32'h40, 32'h10, 7'h00);
    check({n, fl}, {CYC_FILL_CLEAN, 32'd1});
    rd(OP_RDTAG, 9, 0);
    check(rq, {a[31:11], 10'h000, 1'b1});
    op(OP_PREF, AM_SCALE2, a, 32'h1E, 7'h00);
    check({n, fl}, {CYC_FILL_CLEAN, 32'd0});
    miss_count <= MISS_LIMIT;
    op(OP_PREF, AM_INDEX, a, 32'h800, 7'h00);
    check({n, fl}, 0);
    miss_count <= 2'h0;
  endtask

  task automatic t_slot();
    slot = 3'h4;
    rd(OP_RDSTAT, 3, 0);
    check({n, rv}, 0);
    slot = SLOT_SPECIAL;
  endtask

  initial begin
    sys_rst = 1'b1;
    req = '0;
    store_hit = '0;
    miss_count = 2'h0;
    lat = 8'h02;
    slot = SLOT_SPECIAL;
    dram_base = 32'h0001_0000;
    dram_cacheable_limit = 32'h0100_0000;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_alloc_modes();
    t_aperture();
    t_copyback();
    t_lru();
    t_inval();
    t_victim();
    t_prefetch();
    t_slot();
    report_and_stop();
  end

  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
endmodule // dcm_maint_tb

bind dcm_maint dcm_maint_monitor u_mon (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .mem_done(mem_done),
  .stall_q(stall_q), .result_valid_q(result_valid_q), .mem_req_q(mem_req_q));
`default_nettype wire

//--- dv/dcm_mem_model.sv
// main memory stand-in answering whole-block transfers after a set delay
`timescale 1ns/1ps
`default_nettype none
module dcm_mem_model (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire dcm_pkg::dcm_mem_req_t mem_req_q,
  input  wire logic [7:0]            lat,
  output var  logic                  mem_done
);
  import dcm_pkg::*;
  logic [7:0] wait_q;

  // one done pulse per request; a request still held after done is not answered twice
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q   <= 8'h00;
      mem_done <= 1'b0;
    end else begin
      mem_done <= 1'b0;
      if (mem_req_q.valid && !mem_done) begin
        if (wait_q == lat) begin
          mem_done <= 1'b1;
          wait_q   <= 8'h00;
        end else begin
          wait_q <= wait_q + 8'h01;
        end
      end
    end
  end
endmodule // dcm_mem_model
`default_nettype wire

//--- rtl/dcm_maint.sv
// data cache special operations: copyback, invalidate, tag/status read, allocate, prefetch
// Functional notes
// RQ1 - special operations accepted only from issue slot five
// RQ2 - copyback/invalidate address: register plus scaled offset
// RQ3 - copyback writes only present valid dirty blocks
// RQ4 - copyback stalls 0 miss, 4 clean, >=19 dirty
// RQ5 - copyback clears dirty, block stays valid
// RQ6 - invalidate hit clears valid and dirty, no writeback
// RQ7 - invalidate stalls 2 on hit, else none
// RQ8 - copyback and invalidate make block least recent
// RQ9 - tag/status read address: register plus scaled offset
// RQ10 - tag read: set bits 10..6, way 13..11
// RQ11 - tag read returns tag and valid bit
// RQ12 - status read: set bits 10..6, one stall
// RQ13 - status read returns eight dirty, ten LRU bits
// RQ14 - allocate claims block valid, no memory fetch
// RQ15 - allocate outside cacheable DRAM is discarded
// RQ16 - allocate stalls 3 clean, >=11 dirty victim
// RQ17 - allocate address three forms, block aligned (code also takes the x2 scaled form, four in all)
// RQ18 - prefetch fills in background, none if resident
// RQ19 - prefetch outside cacheable DRAM is discarded
// RQ20 - prefetch dropped with two misses outstanding
// RQ21 - prefetch stalls 3 clean, >=11 dirty victim
// RQ22 - scheduler keeps first port idle meanwhile
// RQ23 - 64-byte blocks, banks from bits 4..2
// RQ24 - stall held exactly the required cycle count
`timescale 1ns/1ps
`default_nettype none
module dcm_maint (
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire dcm_pkg::dcm_req_t    req,
  input  wire dcm_pkg::dcm_store_t  store_hit,
  input  wire logic [1:0]           miss_count,
  input  wire logic [31:0]          dram_base,
  input  wire logic [31:0]          dram_cacheable_limit,
  input  wire logic                 mem_done,
  output var  logic                 stall_q,
  output var  logic [31:0]          result_q,
  output var  logic                 result_valid_q,
  output var  dcm_pkg::dcm_mem_req_t mem_req_q
);
  import dcm_pkg::*;

  logic [TAG_W-1:0]  tag_q   [SETS][WAYS];
  logic [WAYS-1:0]   valid_q [SETS];
  logic [WAYS-1:0]   dirty_q [SETS];
  logic [LRU_W-1:0]  lru_q   [SETS];

  dcm_state_t        state_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              wb_need_q, pf_need_q, pf_busy_q;
  logic [ADDR_W-1:0] wb_addr_q, pf_addr_q;
  logic [SET_W-1:0]  pf_set_q;
  logic [WAY_W-1:0]  pf_way_q;

  logic [ADDR_W-1:0] off_ext, tgt, blk_addr, wb_a;
  logic [SET_W-1:0]  set_i, st_set;
  logic [TAG_W-1:0]  tag_i;
  logic [WAY_W-1:0]  rd_way, hit_way, vic_way, st_way;
  logic [2:0]        miss_total;
  logic [CNT_W-1:0]  stall_n;
  logic              hit, vic_dirty, cacheable, pf_drop, accept;
  logic              wb_go, fill_go, wb_busy, fill_done, st_hit;

  // pairwise-order bit index for pairs a<b among the four way pairs
  function automatic int pair_bit(int a, int b);
    return (a == 0) ? b - 1 : (a == 1) ? b + 1 : 5;
  endfunction

  // true when pair i has been used less recently than pair j
  function automatic logic pair_older(logic [LRU_W-1:0] l, int i, int j);
    return (i < j) ? ~l[pair_bit(i, j)] : l[pair_bit(j, i)];
  endfunction

  // hierarchical LRU: oldest of four pairs, then older way inside it
  function automatic logic [WAY_W-1:0] lru_victim(logic [LRU_W-1:0] l);
    logic [1:0] p;
    logic       ok;
    p = 2'h0;
    for (int i = 0; i < 4; i++) begin
      ok = 1'b1;
      for (int j = 0; j < 4; j++) begin
        if (j != i && !pair_older(l, i, j)) begin
          ok = 1'b0;
        end
      end
      if (ok) begin
        p = 2'(i);
      end
    end
    return {p, ~l[LRU_PAIR_LSB + int'(p)]};
  endfunction

  // mark a way most (mru=1) or least (mru=0) recently used in its set
  function automatic logic [LRU_W-1:0] lru_touch(logic [LRU_W-1:0] l, logic [WAY_W-1:0] w, logic mru);
    logic [LRU_W-1:0] r;
    int               p;
    r = l;
    p = int'(w[2:1]);
    for (int q = 0; q < 4; q++) begin
      if (q < p) begin
        r[pair_bit(q, p)] = ~mru;
      end else if (q > p) begin
        r[pair_bit(p, q)] = mru;
      end
    end
    r[LRU_PAIR_LSB + p] = mru ? w[0] : ~w[0];
    return r;
  endfunction

  // target address, lookup and victim choice
  always_comb begin
    off_ext = {{(ADDR_W - OFF_W - 2){req.offset[OFF_W-1]}}, req.offset, 2'h0}; // RQ2 RQ9
    tgt     = req.first_source_register + off_ext; // RQ2 RQ9
    if (req.op == OP_ALLOC || req.op == OP_PREF) begin
      case (req.amode) // RQ17
        AM_DISP:   tgt = req.first_source_register + off_ext;
        AM_INDEX:  tgt = req.first_source_register + req.second_source_register;
        AM_SCALE2: tgt = req.first_source_register + {req.second_source_register[ADDR_W-2:0], 1'b0};
        default:   tgt = req.first_source_register + {req.second_source_register[ADDR_W-3:0], 2'h0};
      endcase
    end
    // 64-byte blocks; word bank is tgt[BANK_LSB +: BANK_W] inside it
    blk_addr = {tgt[ADDR_W-1:BLOCK_LSB], {BLOCK_LSB{1'b0}}}; // RQ17 RQ23
    set_i    = tgt[SET_LSB +: SET_W]; // RQ10 RQ12
    tag_i    = tgt[TAG_LSB +: TAG_W];
    rd_way   = tgt[WAY_LSB +: WAY_W]; // RQ10
    hit      = 1'b0;
    hit_way  = '0;
    for (int w = 0; w < WAYS; w++) begin
      if (valid_q[set_i][w] && tag_q[set_i][w] == tag_i) begin
        hit     = 1'b1;
        hit_way = WAY_W'(w);
      end
    end
    // free ways are used before evicting anything
    vic_way = lru_victim(lru_q[set_i]);
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (!valid_q[set_i][w]) begin
        vic_way = WAY_W'(w);
      end
    end
    vic_dirty  = valid_q[set_i][vic_way] && dirty_q[set_i][vic_way];
    cacheable  = blk_addr >= dram_base && blk_addr < dram_cacheable_limit; // RQ15 RQ19
    miss_total = {1'b0, miss_count} + {2'h0, pf_busy_q};
    // single fill engine: a prefetch is also dropped while one is in flight
    pf_drop    = miss_total >= {1'b0, MISS_LIMIT} || pf_busy_q; // RQ20
    st_set     = store_hit.addr[SET_LSB +: SET_W];
    st_hit     = 1'b0;
    st_way     = '0;
    for (int w = 0; w < WAYS; w++) begin
      if (valid_q[st_set][w] && tag_q[st_set][w] == store_hit.addr[TAG_LSB +: TAG_W]) begin
        st_hit = store_hit.valid;
        st_way = WAY_W'(w);
      end
    end
  end

  // a new operation is only taken while the core is not stalled
  assign accept    = req.valid && req.slot == SLOT_SPECIAL && state_q == ST_IDLE; // RQ1
  assign wb_busy   = wb_need_q || (mem_req_q.valid && mem_req_q.write);
  assign fill_done = mem_req_q.valid && !mem_req_q.write && mem_done;

  // stall length and memory traffic each operation needs
  always_comb begin
    stall_n = '0;
    wb_go   = 1'b0;
    wb_a    = {tag_q[set_i][vic_way], set_i, {BLOCK_LSB{1'b0}}};
    fill_go = 1'b0;
    case (req.op)
      OP_COPYBACK: begin
        if (hit) begin
          if (dirty_q[set_i][hit_way]) begin
            stall_n = CYC_CB_DIRTY; // RQ4
            wb_go   = 1'b1; // RQ3
            wb_a    = blk_addr;
          end else begin
            stall_n = CYC_CB_CLEAN; // RQ4
          end
        end
      end
      OP_INVAL: begin
        if (hit) begin
          stall_n = CYC_INVAL; // RQ7
        end
      end
      OP_RDSTAT: begin
        stall_n = CYC_RDSTAT; // RQ12
      end
      OP_ALLOC: begin
        if (cacheable) begin // RQ15
          if (!hit && vic_dirty) begin
            stall_n = CYC_FILL_DIRTY; // RQ16
            wb_go   = 1'b1;
          end else begin
            stall_n = CYC_FILL_CLEAN; // RQ16
          end
        end
      end
      OP_PREF: begin
        if (cacheable) begin // RQ19
          if (hit) begin
            stall_n = CYC_FILL_CLEAN; // RQ18 RQ21
          end else if (!pf_drop) begin // RQ20
            fill_go = 1'b1; // RQ18
            if (vic_dirty) begin
              stall_n = CYC_FILL_DIRTY; // RQ21
              wb_go   = 1'b1;
            end else begin
              stall_n = CYC_FILL_CLEAN; // RQ21
            end
          end
        end
      end
      default: ;
    endcase
  end

  // valid, dirty and replacement state
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int s = 0; s < SETS; s++) begin
        valid_q[s] <= '0;
        dirty_q[s] <= '0;
        lru_q[s]   <= LRU_RST;
      end
    end else begin
      if (fill_done) begin
        valid_q[pf_set_q][pf_way_q] <= 1'b1; // RQ18
      end
      if (accept) begin
        case (req.op)
          OP_COPYBACK: begin
            if (hit) begin
              dirty_q[set_i][hit_way] <= 1'b0; // RQ5
              lru_q[set_i]            <= lru_touch(lru_q[set_i], hit_way, 1'b0); // RQ8
            end
          end
          OP_INVAL: begin
            if (hit) begin
              valid_q[set_i][hit_way] <= 1'b0; // RQ6
              dirty_q[set_i][hit_way] <= 1'b0; // RQ6
              lru_q[set_i]            <= lru_touch(lru_q[set_i], hit_way, 1'b0); // RQ8
            end
          end
          OP_ALLOC: begin
            if (cacheable && hit) begin
              lru_q[set_i] <= lru_touch(lru_q[set_i], hit_way, 1'b1);
            end else if (cacheable) begin
              valid_q[set_i][vic_way] <= 1'b1; // RQ14
              dirty_q[set_i][vic_way] <= 1'b0;
              lru_q[set_i]            <= lru_touch(lru_q[set_i], vic_way, 1'b1);
            end
          end
          OP_PREF: begin
            if (cacheable && hit) begin
              lru_q[set_i] <= lru_touch(lru_q[set_i], hit_way, 1'b1);
            end else if (fill_go) begin
              // line stays invalid until the fill lands
              valid_q[set_i][vic_way] <= 1'b0;
              dirty_q[set_i][vic_way] <= 1'b0;
              lru_q[set_i]            <= lru_touch(lru_q[set_i], vic_way, 1'b1);
            end
          end
          default: ;
        endcase
      end else if (st_hit) begin
        dirty_q[st_set][st_way] <= 1'b1;
        lru_q[st_set]           <= lru_touch(lru_q[st_set], st_way, 1'b1);
      end
    end
  end

  // tags carry no reset; they are meaningless while valid is clear
  always_ff @(posedge sys_clk) begin
    if (accept && ((req.op == OP_ALLOC && cacheable && !hit) || fill_go)) begin
      tag_q[set_i][vic_way] <= tag_i; // RQ14
    end
  end

  // core stall: high for exactly stall_n cycles, longer only for a writeback
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      stall_q <= 1'b0;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept && stall_n != '0) begin
            stall_q <= 1'b1; // RQ24
            cnt_q   <= stall_n - 5'h01;
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 5'h01;
          end else if (!wb_busy) begin // RQ4 RQ16 RQ21
            stall_q <= 1'b0; // RQ24
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // memory port: one block transfer at a time, writebacks first
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_req_q <= '0;
      wb_need_q <= 1'b0;
      wb_addr_q <= '0;
      pf_need_q <= 1'b0;
      pf_busy_q <= 1'b0;
      pf_addr_q <= '0;
      pf_set_q  <= '0;
      pf_way_q  <= '0;
    end else begin
      if (mem_req_q.valid) begin
        if (mem_done) begin
          mem_req_q.valid <= 1'b0;
          if (!mem_req_q.write) begin
            pf_busy_q <= 1'b0;
          end
        end
      end else if (wb_need_q) begin
        mem_req_q <= '{valid: 1'b1, write: 1'b1, addr: wb_addr_q}; // RQ3
        wb_need_q <= 1'b0;
      end else if (pf_need_q) begin
        mem_req_q <= '{valid: 1'b1, write: 1'b0, addr: pf_addr_q}; // RQ18
        pf_need_q <= 1'b0;
      end
      if (accept && wb_go) begin
        wb_need_q <= 1'b1;
        wb_addr_q <= wb_a;
      end
      if (accept && fill_go) begin
        pf_need_q <= 1'b1;
        pf_busy_q <= 1'b1;
        pf_addr_q <= blk_addr;
        pf_set_q  <= set_i;
        pf_way_q  <= vic_way;
      end
    end
  end

  // tag and status read results, one cycle after the request
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_q       <= '0;
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= accept && (req.op == OP_RDTAG || req.op == OP_RDSTAT);
      if (accept && req.op == OP_RDTAG) begin
        result_q <= {tag_q[set_i][rd_way], 10'h000, valid_q[set_i][rd_way]}; // RQ11
      end else if (accept && req.op == OP_RDSTAT) begin
        result_q <= {14'h0000, dirty_q[set_i], lru_q[set_i]}; // RQ13
      end
    end
  end

endmodule // dcm_maint
`default_nettype wire

//--- rtl/dcm_pkg.sv
// types and constants shared by the data cache maintenance logic
`default_nettype none
package dcm_pkg;

  localparam int ADDR_W       = 32;
  localparam int TAG_W        = 21;
  localparam int SETS         = 32;
  localparam int WAYS         = 8;
  localparam int SET_W        = 5;
  localparam int WAY_W        = 3;
  localparam int SET_LSB      = 6;
  localparam int WAY_LSB      = 11;
  localparam int TAG_LSB      = 11;
  localparam int BLOCK_LSB    = 6;
  localparam int BANK_LSB     = 2;
  localparam int BANK_W       = 3;
  localparam int LRU_W        = 10;
  localparam int LRU_PAIR_LSB = 6;
  localparam int OFF_W        = 7;
  localparam int CNT_W        = 5;

  localparam logic [2:0]       SLOT_SPECIAL   = 3'h5;
  localparam logic [CNT_W-1:0] CYC_CB_CLEAN   = 5'h04;
  localparam logic [CNT_W-1:0] CYC_CB_DIRTY   = 5'h13;
  localparam logic [CNT_W-1:0] CYC_INVAL      = 5'h02;
  localparam logic [CNT_W-1:0] CYC_RDSTAT     = 5'h01;
  localparam logic [CNT_W-1:0] CYC_FILL_CLEAN = 5'h03;
  localparam logic [CNT_W-1:0] CYC_FILL_DIRTY = 5'h0B;
  localparam logic [LRU_W-1:0] LRU_RST        = 10'h000;
  localparam logic [1:0]       MISS_LIMIT     = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE, OP_COPYBACK, OP_INVAL, OP_RDTAG, OP_RDSTAT, OP_ALLOC, OP_PREF
  } dcm_op_t;

  typedef enum logic [1:0] {AM_DISP, AM_INDEX, AM_SCALE2, AM_SCALE4} dcm_amode_t;

  typedef enum logic {ST_IDLE, ST_HOLD} dcm_state_t;

  typedef struct packed {
    logic              valid;
    logic [2:0]        slot;
    dcm_op_t           op;
    dcm_amode_t        amode;
    logic [ADDR_W-1:0] first_source_register;
    logic [ADDR_W-1:0] second_source_register;
    logic [OFF_W-1:0]  offset;
  } dcm_req_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } dcm_store_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } dcm_mem_req_t;

endpackage
`default_nettype wire
